/* File: dv/ir_edge_capture_timer_assertions.sv */
// Port-level assertions for the IR edge capture timer
`timescale 1ns/10ps
module ir_capture_checker
   import ir_capture_pkg::*;
#(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned COUNT_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ir_pin,
   input wire logic irq_pulse,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [ADDR_W-1:0] aw_q;
   logic [ADDR_W-1:0] ar_q;
   logic aw_ok;
   logic ar_ok;
   // Addresses of the transfers in flight
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   assign aw_ok = aw_q[ADDR_W-1:2] >= IDX_FLAGS && aw_q[ADDR_W-1:2] <= IDX_MODE;
   assign ar_ok = ar_q[ADDR_W-1:2] >= IDX_FLAGS && ar_q[ADDR_W-1:2] <= IDX_MODE;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
   property p_bresp_map;
      s_axi_bvalid |-> s_axi_bresp == (aw_ok ? RESP_OKAY : RESP_SLVERR);
   endproperty
   a_bresp_map: assert property (p_bresp_map) else $error("write response code wrong");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   property p_ar_hold;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_hold: assert property (p_ar_hold) else $error("read address taken during data");
   property p_ar_release;
      $fell(s_axi_rvalid) |-> s_axi_arready;
   endproperty
   a_ar_release: assert property (p_ar_release) else $error("read address not reopened");
   property p_rd_unmapped;
      s_axi_rvalid && !ar_ok |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answer wrong");
   property p_flags_rsvd;
      s_axi_rvalid && ar_q[ADDR_W-1:2] == IDX_FLAGS |-> s_axi_rdata[31:3] == 29'h0;
   endproperty
   a_flags_rsvd: assert property (p_flags_rsvd) else $error("flag reserved bits set");
   property p_ctrl_rsvd;
      s_axi_rvalid && ar_q[ADDR_W-1:2] == IDX_CONTROL |-> s_axi_rdata[31:7] == 25'h0;
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bit set");
   property p_irq_pulse;
      irq_pulse |=> !irq_pulse;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
endmodule // ir_capture_checker
bind ir_edge_capture_timer ir_capture_checker #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) chk_inst (
   .aclk(aclk), .aresetn(aresetn), .ir_pin(ir_pin), .irq_pulse(irq_pulse),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* File: dv/ir_edge_capture_timer_test.sv */
// Self-checking bench for the IR edge capture timer
`timescale 1ns/10ps
module ir_edge_capture_timer_test;
   import ir_capture_pkg::*;
   localparam int CW = 12;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ir_pin, irq_pulse, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h1;
   logic [1:0] bresp, rresp;
   int n_mismatch = 0, total_checks = 0, irq_n = 0, cyc = 0;
   ir_edge_capture_timer #(.ADDR_W(8), .COUNT_W(CW)) ir_edge_capture_timer_inst (
      .aclk(aclk), .aresetn(aresetn), .ir_pin(ir_pin), .irq_pulse(irq_pulse),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   ir_receiver_model ir_receiver_model_inst (.aclk(aclk), .ir_out(ir_pin));
   always #4 aclk = ~aclk;
   task automatic test_done();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Cycle count, interrupt count and watchdog
   always @(negedge aclk) begin
      cyc++;
      if (irq_pulse === 1'b1) irq_n++;
      if (cyc == 60000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic near(input logic [15:0] got, input int e, input int tol);
      total_checks++;
      if ((got >= e - tol && got <= e + tol) !== 1'b1) begin
         n_mismatch++;
         $display("ERROR t=%0t value %h not near %0d", $time, got, e);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask
   task automatic rc(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(d, {24'h0, e});
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic rv(output logic [15:0] v);
      logic [31:0] lo, hi;
      logic [1:0] r;
      rd(IDX_VALUE_LOW, lo, r);
      rd(IDX_VALUE_HIGH, hi, r);
      v = {hi[7:0], lo[7:0]};
   endtask
   initial begin
      int divs[4] = '{32, 4, 8, 16};
      int wid[4] = '{0, 2, 8, 16};
      logic [7:0] ef[4] = '{8'h00, 8'h04, 8'h02, 8'h06};
      logic [15:0] v, v1;
      int k, t0, t1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(IDX_FLAGS, 8'h00, RESP_OKAY);
      rc(IDX_CONTROL, 8'h40, RESP_OKAY);
      rc(IDX_VALUE_LOW, 8'h00, RESP_OKAY);
      rc(IDX_VALUE_HIGH, 8'h00, RESP_OKAY);
      rc(IDX_MODE, 8'h00, RESP_OKAY);
      rc(6'h06, 8'h00, RESP_SLVERR);
      wr(6'h00, 8'h55, RESP_SLVERR);
      wr(IDX_CONTROL, 8'hff, RESP_OKAY);
      rc(IDX_CONTROL, 8'h7f, RESP_OKAY);
      wstrb <= 4'h0;
      wr(IDX_CONTROL, 8'h00, RESP_OKAY);
      rc(IDX_CONTROL, 8'h7f, RESP_OKAY);
      wstrb <= 4'h1;
      wr(IDX_FLAGS, 8'hf8, RESP_OKAY);
      rc(IDX_FLAGS, 8'h00, RESP_OKAY);
      wr(IDX_VALUE_LOW, 8'hff, RESP_OKAY);
      rc(IDX_VALUE_LOW, 8'h00, RESP_OKAY);
      wr(IDX_CONTROL, 8'h60, RESP_OKAY);
      ir_receiver_model_inst.burst(10, 20);
      rc(IDX_FLAGS, 8'h00, RESP_OKAY);
      for (k = 0; k < 4; k++) begin
         wr(IDX_CONTROL, {2'b00, k[1:0], 4'h1}, RESP_OKAY);
         wr(IDX_FLAGS, 8'h07, RESP_OKAY);
         t0 = irq_n;
         ir_receiver_model_inst.burst(10, 20);
         rc(IDX_FLAGS, ef[k], RESP_OKAY);
         chk(irq_n - t0, $countones(ef[k]));
      end
      t0 = irq_n;
      wr(IDX_FLAGS, 8'h02, RESP_OKAY);
      rc(IDX_FLAGS, 8'h04, RESP_OKAY);
      chk(irq_n - t0, 1);
      wr(IDX_FLAGS, 8'h00, RESP_OKAY);
      rc(IDX_FLAGS, 8'h04, RESP_OKAY);
      for (k = 1; k < 4; k++) begin
         wr(IDX_CONTROL, {4'h2, k[1:0], 2'h1}, RESP_OKAY);
         wr(IDX_FLAGS, 8'h07, RESP_OKAY);
         ir_receiver_model_inst.burst(wid[k] - 1, 30);
         rc(IDX_FLAGS, 8'h00, RESP_OKAY);
         ir_receiver_model_inst.burst(wid[k] + 2, 30);
         rc(IDX_FLAGS, 8'h02, RESP_OKAY);
      end
      for (k = 0; k < 4; k++) begin
         wr(IDX_CONTROL, {6'h08, k[1:0]}, RESP_OKAY);
         ir_receiver_model_inst.burst(10, 2550);
         ir_receiver_model_inst.burst(10, 20);
         rv(v);
         near(v, 2560 / divs[k], 1);
      end
      repeat (400) @(posedge aclk);
      wr(IDX_MODE, 8'h01, RESP_OKAY);
      wr(IDX_CONTROL, 8'h61, RESP_OKAY);
      wr(IDX_CONTROL, 8'h21, RESP_OKAY);
      repeat (800) @(posedge aclk);
      t0 = cyc;
      ir_receiver_model_inst.burst(10, 20);
      rv(v);
      near(v, 200, 2);
      t1 = cyc;
      ir_receiver_model_inst.burst(10, 20);
      rv(v1);
      near(v1, 200 + (t1 - t0) / 4, 2);
      wr(IDX_CONTROL, 8'h41, RESP_OKAY);
      wr(IDX_FLAGS, 8'h07, RESP_OKAY);
      wr(IDX_CONTROL, 8'h01, RESP_OKAY);
      t0 = irq_n;
      t1 = cyc;
      while (irq_n == t0) @(posedge aclk);
      near(cyc - t1, (1 << CW) * 4, 8);
      rc(IDX_FLAGS, 8'h01, RESP_OKAY);
      test_done();
   end
endmodule // ir_edge_capture_timer_test

/* File: dv/ir_receiver_model.sv */
// Behavioural IR receiver output feeding the capture pin
`timescale 1ns/10ps
module ir_receiver_model (
   input wire logic aclk,
   output logic ir_out
);
   initial ir_out = 1'b1;
   // Low burst then idle high, lengths in clocks
   task automatic burst(input int lo, input int hi);
      ir_out <= 1'b0;
      repeat (lo) @(posedge aclk);
      ir_out <= 1'b1;
      repeat (hi) @(posedge aclk);
   endtask
endmodule // ir_receiver_model

/* File: hw/ir_capture_pkg.sv */
// Constants, field layouts and carrier types for the IR edge capture timer
package ir_capture_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FLAGS = 6'h01;
   localparam logic [5:0] IDX_CONTROL = 6'h02;
   localparam logic [5:0] IDX_VALUE_LOW = 6'h03;
   localparam logic [5:0] IDX_VALUE_HIGH = 6'h04;
   localparam logic [5:0] IDX_MODE = 6'h05;
   localparam int unsigned WORD_LSB = 2;

   // Flag bit positions in capture_flags
   localparam int unsigned FLAG_RISE_BIT = 2;
   localparam int unsigned FLAG_FALL_BIT = 1;
   localparam int unsigned FLAG_TOUT_BIT = 0;
   // Selector bit position in the mode register
   localparam int unsigned MODE_BIT = 0;

   typedef struct packed {
      logic rise;
      logic fall;
      logic tout;
   } flags_type;

   typedef struct packed {
      logic timer_freeze;
      logic [1:0] edge_select;
      logic [1:0] pulse_reject_width;
      logic [1:0] count_prescale;
   } control_type;

   localparam control_type CONTROL_RESET = 7'h40;
   localparam flags_type FLAGS_RESET = 3'h0;
   localparam logic [15:0] VALUE_RESET = 16'h0000;

   // Edge select codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Pulse reject codes and widths in system clocks
   localparam logic [1:0] REJECT_OFF = 2'h0;
   localparam logic [1:0] REJECT_SHORT = 2'h1;
   localparam logic [1:0] REJECT_MID = 2'h2;
   localparam logic [1:0] REJECT_LONG = 2'h3;
   localparam logic [4:0] REJECT_SHORT_CLKS = 5'h02;
   localparam logic [4:0] REJECT_MID_CLKS = 5'h08;
   localparam logic [4:0] REJECT_LONG_CLKS = 5'h10;

   // Prescale codes and divisors
   localparam logic [1:0] PRESCALE_32 = 2'h0;
   localparam logic [1:0] PRESCALE_4 = 2'h1;
   localparam logic [1:0] PRESCALE_8 = 2'h2;
   localparam logic [1:0] PRESCALE_16 = 2'h3;
   localparam logic [5:0] DIV_32 = 6'h20;
   localparam logic [5:0] DIV_4 = 6'h04;
   localparam logic [5:0] DIV_8 = 6'h08;
   localparam logic [5:0] DIV_16 = 6'h10;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/ir_edge_capture_timer.sv */
// IR edge capture timer with AXI4-Lite register slave
//
// What this block does
// - Each 16-bit capture is read as a low byte and a high byte in two registers.
// - The mode selector chooses time since the last capture event or since the last overflow.
// - The flags register shows rising captured, falling captured and counter time-out.
// - Writing 1 to a flag clears it, writing 0 leaves it, and the service routine does so.
// - A pending flag of one edge survives the other edge and re-raises the request when served.
// - A second edge of the same kind overwrites the pending one instead of queueing.
// - The freeze control bit halts the counter, and it comes out of reset set.
// - Freezing also resets the counter so it restarts from zero.
// - The edge select field picks none, rising, falling or both edges.
// - The reject field filters pulses under 2, 8 or 16 clocks, or none.
// - The prescale field divides the clock by 32, 4, 8 or 16 for the counter.
// - Both capture bytes are read-only and read zero after reset.
// - Reserved flag bits 7..3 and control bit 7 read zero and ignore writes.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ir_edge_capture_timer
   import ir_capture_pkg::*;
#(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned COUNT_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ir_pin,
   output logic irq_pulse,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   function automatic logic is_mapped(input logic [5:0] idx);
      return (idx >= IDX_FLAGS) && (idx <= IDX_MODE);
   endfunction

   function automatic logic [5:0] word_of(input logic [ADDR_W-1:0] addr);
      return 6'(addr >> WORD_LSB);
   endfunction

   // Input synchroniser
   logic sync1_q, sync2_q;
   logic filt_level, prev_q, prev_d;
   logic tick;

   // Register state
   control_type control_q, control_d;
   flags_type flags_q, flags_d;
   logic mode_q, mode_d;
   logic [COUNT_W-1:0] count_q, count_d;
   logic [15:0] value_q, value_d;
   logic irq_q, irq_d;

   // Bus state
   logic aw_held_q, aw_held_d;
   logic w_held_q, w_held_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   // Events
   logic rise_ev, fall_ev, wrap_ev, capture_ev;
   logic do_write;
   logic [5:0] wr_idx, rd_idx;
   logic flags_wr, control_wr, mode_wr;
   flags_type clear_mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= ir_pin;
         sync2_q <= sync1_q;
      end
   end

   ir_pulse_filter u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw(sync2_q),
      .width_sel(control_q.pulse_reject_width),
      .level(filt_level)
   );

   ir_prescaler u_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(control_q.timer_freeze),
      .sel(control_q.count_prescale),
      .tick(tick)
   );

   // Write decode
   always_comb begin
      do_write = aw_held_q && w_held_q && !bvalid_q;
      wr_idx = word_of(awaddr_q);
      flags_wr = do_write && wlane_q && (wr_idx == IDX_FLAGS);
      control_wr = do_write && wlane_q && (wr_idx == IDX_CONTROL);
      mode_wr = do_write && wlane_q && (wr_idx == IDX_MODE);
      clear_mask.rise = flags_wr && wbyte_q[FLAG_RISE_BIT];
      clear_mask.fall = flags_wr && wbyte_q[FLAG_FALL_BIT];
      clear_mask.tout = flags_wr && wbyte_q[FLAG_TOUT_BIT];
   end

   // Edge and counter events
   always_comb begin
      prev_d = filt_level;
      rise_ev = 1'b0;
      fall_ev = 1'b0;
      if (!control_q.timer_freeze) begin
         case (control_q.edge_select)
            EDGE_RISE: rise_ev = filt_level && !prev_q;
            EDGE_FALL: fall_ev = !filt_level && prev_q;
            EDGE_BOTH: begin
               rise_ev = filt_level && !prev_q;
               fall_ev = !filt_level && prev_q;
            end
            EDGE_NONE: begin
               rise_ev = 1'b0;
               fall_ev = 1'b0;
            end
            default: begin
               rise_ev = 1'b0;
               fall_ev = 1'b0;
            end
         endcase
      end
      capture_ev = rise_ev || fall_ev;
      wrap_ev = tick && !control_q.timer_freeze && (count_q == {COUNT_W{1'b1}});
   end

   // Counter, capture, flags and request
   always_comb begin
      count_d = count_q;
      value_d = value_q;
      if (control_q.timer_freeze) begin
         count_d = '0;
      end else if (capture_ev && !mode_q) begin
         count_d = '0;
      end else if (tick) begin
         count_d = count_q + COUNT_W'(1);
      end
      if (capture_ev) begin
         value_d = 16'(count_q);
      end
      flags_d.rise = rise_ev || (flags_q.rise && !clear_mask.rise);
      flags_d.fall = fall_ev || (flags_q.fall && !clear_mask.fall);
      flags_d.tout = wrap_ev || (flags_q.tout && !clear_mask.tout);
      irq_d = capture_ev || wrap_ev;
      if ((clear_mask & flags_q) != FLAGS_RESET && flags_d != FLAGS_RESET) begin
         irq_d = 1'b1;
      end
      control_d = control_q;
      if (control_wr) begin
         control_d = control_type'(wbyte_q[6:0]);
      end
      mode_d = mode_q;
      if (mode_wr) begin
         mode_d = wbyte_q[MODE_BIT];
      end
   end

   // Write channels
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_held_d = 1'b1;
         wbyte_d = s_axi_wdata[7:0];
         wlane_d = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_held_d && !bvalid_d;
      wready_d = !w_held_d && !bvalid_d;
   end

   // Read channel
   always_comb begin
      rd_idx = word_of(s_axi_araddr);
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         case (rd_idx)
            IDX_FLAGS: rdata_d = {29'h0, flags_q};
            IDX_CONTROL: rdata_d = {25'h0, control_q};
            IDX_VALUE_LOW: rdata_d = {24'h0, value_q[7:0]};
            IDX_VALUE_HIGH: rdata_d = {24'h0, value_q[15:8]};
            IDX_MODE: rdata_d = {31'h0, mode_q};
            default: rdata_d = 32'h0;
         endcase
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b1;
         control_q <= CONTROL_RESET;
         flags_q <= FLAGS_RESET;
         mode_q <= 1'b0;
         count_q <= '0;
         value_q <= VALUE_RESET;
         irq_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         control_q <= control_d;
         flags_q <= flags_d;
         mode_q <= mode_d;
         count_q <= count_d;
         value_q <= value_d;
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign irq_pulse = irq_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule // ir_edge_capture_timer

/* File: hw/ir_prescaler.sv */
// Capture counter clock divider producing one-cycle enable pulses
`timescale 1ns/10ps
module ir_prescaler
   import ir_capture_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic [1:0] sel,
   output logic tick
);
   logic [5:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic [5:0] divisor;

   always_comb begin
      case (sel)
         PRESCALE_32: divisor = DIV_32;
         PRESCALE_4: divisor = DIV_4;
         PRESCALE_8: divisor = DIV_8;
         PRESCALE_16: divisor = DIV_16;
         default: divisor = DIV_32;
      endcase
   end

   always_comb begin
      cnt_d = cnt_q + 6'h01;
      tick_d = 1'b0;
      if (clear) begin
         cnt_d = 6'h00;
      end else if (cnt_q >= divisor - 6'h01) begin
         cnt_d = 6'h00;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule // ir_prescaler

/* File: hw/ir_pulse_filter.sv */
// Glitch filter: a level change is accepted once stable for the set width
`timescale 1ns/10ps
module ir_pulse_filter
   import ir_capture_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic raw,
   input wire logic [1:0] width_sel,
   output logic level
);
   logic [4:0] cnt_q, cnt_d;
   logic level_q, level_d;
   logic [4:0] need;

   always_comb begin
      case (width_sel)
         REJECT_SHORT: need = REJECT_SHORT_CLKS;
         REJECT_MID: need = REJECT_MID_CLKS;
         REJECT_LONG: need = REJECT_LONG_CLKS;
         default: need = REJECT_SHORT_CLKS;
      endcase
   end

   always_comb begin
      cnt_d = 5'h00;
      level_d = level_q;
      if (width_sel == REJECT_OFF) begin
         level_d = raw;
      end else if (raw != level_q) begin
         if (cnt_q + 5'h01 >= need) begin
            level_d = raw;
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 5'h00;
         level_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule // ir_pulse_filter
